// ==== rtl/twt_cfg.svh ====
// Constants for the two-wire target interface
`ifndef TWT_CFG_SVH
`define TWT_CFG_SVH
// ****************************************
// Timing
// ****************************************
`define TWT_CLK_MHZ 200
`define TWT_FILT_LS_NS 50
`define TWT_FILT_HS_NS 10
`define TWT_FILT_LS_CYC ((`TWT_FILT_LS_NS * `TWT_CLK_MHZ) / 1000)
`define TWT_FILT_HS_CYC ((`TWT_FILT_HS_NS * `TWT_CLK_MHZ) / 1000)
// ****************************************
// Addresses and codes
// ****************************************
`define TWT_ADDR_OPT0 7'h41
`define TWT_ADDR_OPT1 7'h42
`define TWT_ADDR_OPT2 7'h6A
`define TWT_ADDR_OPT3 7'h6B
`define TWT_ADDR_TEST 7'h49
`define TWT_GCALL_BYTE 8'h00
`define TWT_HS_CODE 5'h01
`define TWT_BYTE_BITS 4'h8
`define TWT_FIFO_DEPTH 8
`endif

// ==== rtl/twt_fifo.sv ====
// Write FIFO between bus engine and register side
`timescale 1ns/1ps
module twt_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  // Storage and pointers
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  // Registered non-empty flag, drives the valid output
  logic valid_q;
  logic wr, rd;
  // ****************************************
  // Next pointers
  // ****************************************
  always_comb begin
    wr = i_in_valid && o_in_ready;
    rd = o_out_valid && i_out_ready;
    wp_d = wp_q;
    rp_d = rp_q;
    if (wr) begin
      wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
    end
    if (rd) begin
      rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
  end
  // Registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      valid_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      valid_q <= (cnt_d != '0);
    end
  end
  // Data array, no reset needed
  always_ff @(posedge i_sys_clk) begin
    if (wr) begin
      mem_q[wp_q] <= i_in_data;
    end
  end
  // Ready from count; valid straight from its flop
  assign o_in_ready = (cnt_q != (AW+1)'(D));
  assign o_out_valid = valid_q;
  assign o_out_data = mem_q[rp_q];
endmodule

// ==== rtl/twt_pkg.sv ====
// Types for the two-wire target interface
package twt_pkg;
  // Bus engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_MACK = 5'b10000
  } twt_state_t;
  // Meaning of the byte being received
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_PTR = 2'h1,
    K_DATA = 2'h2
  } twt_kind_t;
endpackage

// ==== rtl/twt_target.sv ====
// Two-wire bus target engine with register access port
`timescale 1ns/1ps
`include "twt_cfg.svh"
// Operation
// - Target only, answers own 7-bit address
// - Transfers both ways up to 1MHz
// - SDA input; open-drain drive for ack/data
// - One bit per SCL period, sampled high
// - SDA fall/rise with SCL high: START/STOP
// - Repeated START restarts address reception
// - After STOP or miss, ignore SCL
// - Nine-bit packet; ack held low
// - Nack releases SDA through ninth clock
// - Bytes MSB first, then acknowledge
// - Multibyte values least significant byte first
// - Option 0 gives 0x41, 1 gives 0x42
// - Options 2,3 give 0x6A,0x6B; others nacked
// - Test address only while unlocked
// - Never stretch SCL
// - General call address left unacknowledged
// - Any rate zero to 1MHz
// - Power-up and STOP restore slow filters
// - High-speed code switches filter set
// - Register pointer byte follows write address
// - Data loaded at ack rising edge
// - Repeated START keeps filter setting
module twt_target #(
  parameter int FIFO_DEPTH = `TWT_FIFO_DEPTH,
  parameter int FILT_LS = `TWT_FILT_LS_CYC,
  parameter int FILT_HS = `TWT_FILT_HS_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic [1:0] i_addr_opt,
  input wire logic i_test_unlock,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_hs_mode
);
  import twt_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  // True when the 7-bit address belongs to us
  function automatic logic addr_hit(input logic [6:0] a,
                                    input logic [1:0] opt,
                                    input logic unlock);
    logic [6:0] main;
    main = `TWT_ADDR_OPT0;
    unique case (opt)
      2'h0: main = `TWT_ADDR_OPT0;
      2'h1: main = `TWT_ADDR_OPT1;
      2'h2: main = `TWT_ADDR_OPT2;
      2'h3: main = `TWT_ADDR_OPT3;
    endcase
    return (a == main) || (unlock && a == `TWT_ADDR_TEST);
  endfunction

  // ****************************************
  // Input sync and glitch filters
  // ****************************************
  logic [1:0] pin_in;
  logic [1:0] s1_q, s2_q;
  logic [1:0] filt_q, filt_d, filt_p_q;
  logic [3:0] fcnt_q [2];
  logic [3:0] fcnt_d [2];
  logic hs_q, hs_d;
  logic [3:0] flim;

  assign pin_in = {i_sda, i_scl};
  assign flim = hs_q ? 4'(FILT_HS) : 4'(FILT_LS);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      // Follow input only after it holds steady
      always_comb begin
        filt_d[g] = filt_q[g];
        fcnt_d[g] = 4'h0;
        if (s2_q[g] != filt_q[g]) begin
          fcnt_d[g] = fcnt_q[g] + 4'h1;
          if (fcnt_d[g] >= flim) begin
            filt_d[g] = s2_q[g];
            fcnt_d[g] = 4'h0;
          end
        end
      end
      // Two-flop sync then filter state
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1_q[g] <= 1'b1;
          s2_q[g] <= 1'b1;
          filt_q[g] <= 1'b1;
          filt_p_q[g] <= 1'b1;
          fcnt_q[g] <= 4'h0;
        end else begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          filt_q[g] <= filt_d[g];
          filt_p_q[g] <= filt_q[g];
          fcnt_q[g] <= fcnt_d[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Edge and condition detect
  // ****************************************
  logic scl_f, sda_f, scl_rise, scl_fall;
  logic start_det, stop_det;
  assign scl_f = filt_q[0];
  assign sda_f = filt_q[1];
  // edge driven, any rate down to zero
  assign scl_rise = scl_f && !filt_p_q[0];
  assign scl_fall = !scl_f && filt_p_q[0];
  // SDA edges while SCL stays high
  assign start_det = scl_f && filt_p_q[0] && filt_p_q[1] && !sda_f;
  assign stop_det = scl_f && filt_p_q[0] && !filt_p_q[1] && sda_f;

  // ****************************************
  // Bus engine
  // ****************************************
  twt_state_t st_q, st_d;
  twt_kind_t kind_q, kind_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic ack_q, ack_d;
  logic oe_q, oe_d;
  logic push;
  logic fifo_rdy;

  // Next state of the engine
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    ack_d = ack_q;
    oe_d = oe_q;
    hs_d = hs_q;
    push = 1'b0;
    if (stop_det) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      hs_d = 1'b0;
    end else if (start_det) begin
      st_d = ST_RX;
      kind_d = K_ADDR;
      cnt_d = 4'h0;
      rw_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          st_d = ST_IDLE;
        end
        ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `TWT_BYTE_BITS) begin
            st_d = ST_ACK;
            ack_d = 1'b0;
            unique case (kind_q)
              K_ADDR: begin
                if (sh_q[7:3] == `TWT_HS_CODE) begin
                  hs_d = 1'b1;
                  st_d = ST_IDLE;
                end else if (sh_q != `TWT_GCALL_BYTE &&
                    addr_hit(sh_q[7:1], i_addr_opt,
                             i_test_unlock)) begin
                  ack_d = 1'b1;
                  rw_d = sh_q[0];
                end else begin
                  st_d = ST_IDLE;
                end
              end
              K_PTR: begin
                ack_d = 1'b1;
                ptr_d = sh_q;
              end
              default: begin
                // Full buffer answers with a nack
                ack_d = fifo_rdy;
              end
            endcase
            oe_d = ack_d && (st_d == ST_ACK);
          end
        end
        ST_ACK: begin
          if (scl_rise && ack_q && kind_q == K_DATA) begin
            // byte takes effect at ack rise
            push = 1'b1;
            ptr_d = ptr_q + 8'h01;
          end else if (scl_fall) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            if (!ack_q) begin
              st_d = ST_IDLE;
            end else if (kind_q == K_ADDR && rw_q) begin
              st_d = ST_TX;
              sh_d = i_rd_data;
              oe_d = !i_rd_data[7];
              ptr_d = ptr_q + 8'h01;
            end else begin
              st_d = ST_RX;
              kind_d = (kind_q == K_ADDR) ? K_PTR : K_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == `TWT_BYTE_BITS) begin
              st_d = ST_MACK;
              oe_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = !sh_q[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            // Controller ack asks for more
            ack_d = !sda_f;
          end else if (scl_fall) begin
            cnt_d = 4'h0;
            if (ack_q) begin
              st_d = ST_TX;
              sh_d = i_rd_data;
              oe_d = !i_rd_data[7];
              ptr_d = ptr_q + 8'h01;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      kind_q <= K_ADDR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      hs_q <= hs_d;
    end
  end

  // ****************************************
  // Write buffer and outputs
  // ****************************************
  twt_fifo #(.W(16), .D(FIFO_DEPTH)) u_twt_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push),
    .o_in_ready(fifo_rdy),
    .i_in_data({ptr_q, sh_q}),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data({o_wr_addr, o_wr_data})
  );

  // data line only ever pulled low
  assign o_sda = 1'b0;
  assign o_sda_oe = oe_q;
  assign o_rd_addr = ptr_q;
  assign o_hs_mode = hs_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic addr_end;
  assign addr_end = st_q == ST_RX && kind_q == K_ADDR && scl_fall &&
                    cnt_q == `TWT_BYTE_BITS;

  drive_only_ack_a: assert property (
    oe_q |-> (st_q == ST_ACK || st_q == ST_TX))
    else $error("SDA driven outside ack or read data");
  stop_to_idle_a: assert property (
    stop_det |=> st_q == ST_IDLE && !hs_q && !oe_q)
    else $error("STOP did not idle the engine");
  start_addr_a: assert property (
    start_det |=> st_q == ST_RX && kind_q == K_ADDR && cnt_q == 4'h0)
    else $error("START did not restart address reception");
  sr_keeps_hs_a: assert property (
    start_det && hs_q |=> hs_q)
    else $error("Repeated START changed filter set");
  gcall_nack_a: assert property (
    addr_end && sh_q == `TWT_GCALL_BYTE |=> st_q == ST_IDLE && !oe_q)
    else $error("General call was acknowledged");
  test_lock_a: assert property (
    addr_end && sh_q[7:1] == `TWT_ADDR_TEST && !i_test_unlock &&
    !addr_hit(sh_q[7:1], i_addr_opt, 1'b0) |=> !oe_q)
    else $error("Locked test address acknowledged");
  main_ack_a: assert property (
    addr_end && sh_q != `TWT_GCALL_BYTE &&
    addr_hit(sh_q[7:1], i_addr_opt, 1'b0) |=> oe_q ##1 oe_q)
    else $error("Own address not acknowledged");
  push_at_ack_a: assert property (
    push |-> st_q == ST_ACK && ack_q && scl_rise && kind_q == K_DATA)
    else $error("Write not taken at ack rise");
  push_valid_a: assert property (
    push |=> o_wr_valid)
    else $error("Written byte not offered to register side");
  ptr_step_a: assert property (
    push |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("Pointer did not advance");
  bit_count_a: assert property (
    cnt_q <= `TWT_BYTE_BITS)
    else $error("Byte bit count overran");

  write_c: cover property (push);
  read_c: cover property (st_q == ST_ACK && rw_q ##[1:300] st_q == ST_TX);
  hs_c: cover property (!hs_q ##1 hs_q);
  full_nack_c: cover property (st_q == ST_ACK && !ack_q &&
                               kind_q == K_DATA);
endmodule

// ==== verif/test_twt_target.sv ====
// Self-checking bench for the two-wire target engine
`timescale 1ns/1ps
`include "twt_cfg.svh"
module test_twt_target;
  import twt_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic i_sys_clk, i_rst_n, o_sda, o_sda_oe, i_test_unlock;
  logic o_wr_valid, i_wr_ready, o_hs_mode;
  logic bus_scl, ctrl_pull, bus_sda, ack;
  logic [1:0] i_addr_opt;
  logic [7:0] o_rd_addr, i_rd_data, o_wr_addr, o_wr_data, b;
  int err_count, check_count;
  // Main address of each option code
  localparam logic [6:0] ADDRS [4] = '{`TWT_ADDR_OPT0,
    `TWT_ADDR_OPT1, `TWT_ADDR_OPT2, `TWT_ADDR_OPT3};
  // 200 MHz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // Pulled-up wire; register file is a fixed pattern
  assign bus_sda = ~ctrl_pull & (o_sda_oe ? o_sda : 1'b1);
  assign i_rd_data = o_rd_addr ^ 8'h5A;
  // ****************************************
  // Instances
  // ****************************************
  twt_target #(.FILT_LS(2), .FILT_HS(1)) u_twt_target (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(bus_scl),
    .i_sda(bus_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_addr_opt(i_addr_opt), .i_test_unlock(i_test_unlock),
    .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data),
    .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_hs_mode(o_hs_mode));
  twt_ctrl_model u_twt_ctrl_model (
    .o_scl(bus_scl), .o_pull(ctrl_pull), .i_sda(bus_sda));
  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Start and address byte, ack compared
  task automatic go(input logic [6:0] a, input logic r, input logic e);
    u_twt_ctrl_model.start();
    u_twt_ctrl_model.wr({a, r}, ack);
    chk({7'h00, ack}, {7'h00, e});
  endtask
  // Take one write entry from the FIFO
  task automatic drain(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    #1;
    while (o_wr_valid !== 1'b1 && n < 2000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk({7'h00, o_wr_valid}, 8'h01);
    chk({o_wr_addr}, a);
    chk({o_wr_data}, d);
    @(posedge i_sys_clk) i_wr_ready <= 1'b1;
    @(posedge i_sys_clk) i_wr_ready <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Every option code, a foreign address, ignored bytes
  task automatic t_addr();
    for (int o = 0; o < 4; o++) begin
      @(posedge i_sys_clk) i_addr_opt <= 2'(o);
      go(ADDRS[o], 1'b0, 1'b1);
      u_twt_ctrl_model.stop();
      go(ADDRS[(o + 1) % 4], 1'b0, 1'b0);
      u_twt_ctrl_model.wr({ADDRS[o], 1'b0}, ack);
      chk({7'h00, ack}, 8'h00);
      u_twt_ctrl_model.stop();
    end
    @(posedge i_sys_clk) i_addr_opt <= 2'h0;
  endtask
  // Test address locked and unlocked, general call
  task automatic t_test();
    go(`TWT_ADDR_TEST, 1'b0, 1'b0);
    u_twt_ctrl_model.stop();
    @(posedge i_sys_clk) i_test_unlock <= 1'b1;
    go(`TWT_ADDR_TEST, 1'b0, 1'b1);
    u_twt_ctrl_model.stop();
    go(7'h00, 1'b0, 1'b0);
    u_twt_ctrl_model.stop();
    @(posedge i_sys_clk) i_test_unlock <= 1'b0;
  endtask
  // Fill the FIFO with the register side stalled, then retry
  task automatic t_fifo();
    go(ADDRS[0], 1'b0, 1'b1);
    u_twt_ctrl_model.wr(8'h30, ack);
    chk({7'h00, ack}, 8'h01);
    for (int i = 0; i < 9; i++) begin
      u_twt_ctrl_model.wr(8'(8'hC0 + i), ack);
      chk({7'h00, ack}, {7'h00, i < 8});
    end
    u_twt_ctrl_model.stop();
    for (int i = 0; i < 8; i++) begin
      drain(8'(8'h30 + i), 8'(8'hC0 + i));
    end
    go(ADDRS[0], 1'b0, 1'b1);
    u_twt_ctrl_model.wr(8'h38, ack);
    u_twt_ctrl_model.wr(8'hC8, ack);
    chk({7'h00, ack}, 8'h01);
    u_twt_ctrl_model.stop();
    drain(8'h38, 8'hC8);
  endtask
  // Pointer, repeat start, two bytes read
  task automatic t_read();
    go(ADDRS[0], 1'b0, 1'b1);
    u_twt_ctrl_model.wr(8'h20, ack);
    go(ADDRS[0], 1'b1, 1'b1);
    u_twt_ctrl_model.rd(1'b0, b);
    chk(b, 8'h20 ^ 8'h5A);
    u_twt_ctrl_model.rd(1'b1, b);
    chk(b, 8'h21 ^ 8'h5A);
    u_twt_ctrl_model.stop();
  endtask
  // High-speed code, kept over repeat start, cleared by stop
  task automatic t_hs();
    go(7'h04, 1'b1, 1'b0);
    chk({7'h00, o_hs_mode}, 8'h01);
    go(ADDRS[0], 1'b0, 1'b1);
    chk({7'h00, o_hs_mode}, 8'h01);
    u_twt_ctrl_model.stop();
    repeat (20) @(posedge i_sys_clk);
    #1;
    chk({7'h00, o_hs_mode}, 8'h00);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    i_rst_n = 1'b0;
    i_addr_opt = 2'h0;
    i_test_unlock = 1'b0;
    i_wr_ready = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    #1;
    chk({5'h00, o_sda_oe, o_wr_valid, o_hs_mode}, 8'h00);
    t_addr();
    t_test();
    t_fifo();
    t_read();
    t_hs();
    report_and_stop();
  end
  // Hang guard, well past the expected run
  initial begin
    #300us;
    err_count++;
    report_and_stop();
  end
endmodule

// ==== verif/twt_ctrl_model.sv ====
// Behavioural bus controller that drives the target's two pins
`timescale 1ns/1ps
module twt_ctrl_model (
  output logic o_scl,
  output logic o_pull,
  input wire logic i_sda
);
  // ****************************************
  // Bus timing
  // ****************************************
  // Quarter of the 80 ns bus clock period
  localparam time Q = 20;
  // Both lines rest high and released
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  // ****************************************
  // Bus primitives
  // ****************************************
  // one bit per period
  // Data only moves while the clock is low
  task automatic xfer(input logic b, output logic s);
    #Q o_pull = ~b;
    #Q o_scl = 1'b1;
    #Q s = i_sda;
    #Q o_scl = 1'b0;
  endtask
  // start or repeat start
  // Small offset keeps pin moves off the sampling edge
  task automatic start();
    #1.3;
    if (o_scl === 1'b0) begin
      #Q o_pull = 1'b0;
      #Q o_scl = 1'b1;
    end
    #Q o_pull = 1'b1;
    #Q o_scl = 1'b0;
  endtask
  task automatic stop();
    #Q o_pull = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_pull = 1'b0;
    #Q;
  endtask
  // byte out MSB first, ack on ninth
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(b[i], s);
    end
    xfer(1'b1, s);
    ack = ~s;
  endtask
  // byte in, nack after last byte
  task automatic rd(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, s);
      b[i] = s;
    end
    xfer(last, s);
  endtask
endmodule
